// ===== core/ssos_top.sv
// Servo status outputs: function flags, alarms, brake sequence, AHB-Lite registers.
// Assumes motion and fault inputs synchronous to hclk; one AHB-Lite master.
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
module ssos_top #(
   parameter int MS_DIV = ssos_pkg::MS_CYCLES
) (
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic [31:0]               hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   input  wire ssos_pkg::ssos_motion_t motion_in,
   input  wire ssos_pkg::ssos_fault_t  fault_in,
   input  wire logic                 main_power_in,
   input  wire logic                 servo_enable_in,
   input  wire logic                 alarm_clear_in,
   output logic                      drive_ready_out,
   output logic                      alarm_out,
   output logic                      position_done_out,
   output logic                      brake_release_out,
   output logic                      speed_arrival_out,
   output logic                      torque_arrival_out,
   output logic                      homing_done_out,
   output logic                      zero_speed_out,
   output logic                      motor_power_out,
   output logic [3:0]                do_out,
   output logic                      irq
);
   import ssos_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   logic [1:0]  mode, next_mode;
   logic [15:0] do_sel, next_do_sel;
   logic [15:0] pos_win, pos_lim, spd_arr, trq_spd, zero_spd;
   logic [15:0] hb_thr, hb_hold, hb_dly, hb_spd;
   logic [15:0] next_pos_win, next_pos_lim, next_spd_arr, next_trq_spd;
   logic [15:0] next_zero_spd, next_hb_thr, next_hb_hold, next_hb_dly;
   logic [15:0] next_hb_spd;
   logic [3:0]  int_stat, next_int_stat, int_en, next_int_en;

   // Bus pipeline
   logic        wr_pend, next_wr_pend, rd_pend, next_rd_pend;
   logic [7:0]  addr_q, next_addr_q;
   logic [31:0] next_hrdata;
   logic        next_hreadyout;
   logic        addr_ok;

   function automatic logic [15:0] lo16(input logic [31:0] w);
      lo16 = w[15:0];
   endfunction

   assign addr_ok = hsel && hready && htrans[1];

   ////////////////////////////////////////////////////////////////////////////
   // Status path state
   logic [15:0] spd_abs, dev_abs;
   logic [15:0] ms_cnt, next_ms_cnt;
   logic        ms_tick, next_ms_tick;
   logic [10:0] rdy_cnt, next_rdy_cnt;
   logic [3:0]  err_code, next_err_code;
   logic        excdev, next_excdev;
   logic [7:0]  flags, next_flags;
   logic [3:0]  next_do_out;
   logic [3:0]  events;
   logic        next_irq;
   logic        hb_rel, mtr_pwr, hb_rel_q;
   logic [1:0]  hb_state;

   assign spd_abs = ssos_abs(motion_in.speed);
   assign dev_abs = ssos_abs(motion_in.deviation);

   ////////////////////////////////////////////////////////////////////////////
   // Register writes and read data
   always_comb begin
      next_mode     = mode;
      next_do_sel   = do_sel;
      next_pos_win  = pos_win;
      next_pos_lim  = pos_lim;
      next_spd_arr  = spd_arr;
      next_trq_spd  = trq_spd;
      next_zero_spd = zero_spd;
      next_hb_thr   = hb_thr;
      next_hb_hold  = hb_hold;
      next_hb_dly   = hb_dly;
      next_hb_spd   = hb_spd;
      next_int_en   = int_en;
      next_int_stat = int_stat;
      next_wr_pend  = addr_ok && hwrite;
      next_rd_pend  = addr_ok && !hwrite;
      next_addr_q   = addr_ok ? {haddr[7:2], 2'b00} : addr_q;
      next_hreadyout = !(addr_ok && !hwrite);
      next_hrdata   = hrdata;
      if (wr_pend) begin
         case (addr_q)
            A_MODE:     next_mode     = hwdata[1:0];
            A_DO_SEL:   next_do_sel   = lo16(hwdata);
            A_POS_WIN:  next_pos_win  = lo16(hwdata);
            A_POS_LIM:  next_pos_lim  = lo16(hwdata);
            A_SPD_ARR:  next_spd_arr  = lo16(hwdata);
            A_TRQ_SPD:  next_trq_spd  = lo16(hwdata);
            A_ZERO_SPD: next_zero_spd = lo16(hwdata);
            A_HB_THR:   next_hb_thr   = lo16(hwdata);
            A_HB_HOLD:  next_hb_hold  = lo16(hwdata);
            A_HB_DLY:   next_hb_dly   = lo16(hwdata);
            A_HB_SPD:   next_hb_spd   = lo16(hwdata);
            A_INT_EN:   next_int_en   = hwdata[3:0];
            A_INT_CLR:  next_int_stat = int_stat & ~hwdata[3:0];
            default:    next_mode     = mode;
         endcase
      end
      // Set wins over a clear in the same cycle
      next_int_stat = next_int_stat | events;
      if (rd_pend) begin
         case (addr_q)
            A_MODE:     next_hrdata = {30'h0, mode};
            A_DO_SEL:   next_hrdata = {16'h0, do_sel};
            A_POS_WIN:  next_hrdata = {16'h0, pos_win};
            A_POS_LIM:  next_hrdata = {16'h0, pos_lim};
            A_SPD_ARR:  next_hrdata = {16'h0, spd_arr};
            A_TRQ_SPD:  next_hrdata = {16'h0, trq_spd};
            A_ZERO_SPD: next_hrdata = {16'h0, zero_spd};
            A_HB_THR:   next_hrdata = {16'h0, hb_thr};
            A_HB_HOLD:  next_hrdata = {16'h0, hb_hold};
            A_HB_DLY:   next_hrdata = {16'h0, hb_dly};
            A_HB_SPD:   next_hrdata = {16'h0, hb_spd};
            A_STATUS:   next_hrdata = {12'h000, hb_state, mtr_pwr, hb_rel, err_code,
                                       do_out, flags};
            A_INT_STAT: next_hrdata = {28'h0, int_stat};
            A_INT_EN:   next_hrdata = {28'h0, int_en};
            default:    next_hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode      <= MODE_POS;
         do_sel    <= 16'h4321;
         pos_win   <= 16'h000A;
         pos_lim   <= 16'h7530;
         spd_arr   <= 16'h01F4;
         trq_spd   <= 16'h01F4;
         zero_spd  <= 16'h000A;
         hb_thr    <= 16'h001E;
         hb_hold   <= 16'h0064;
         hb_dly    <= 16'h01F4;
         hb_spd    <= 16'h001E;
         int_en    <= 4'h0;
         int_stat  <= 4'h0;
         wr_pend   <= 1'b0;
         rd_pend   <= 1'b0;
         addr_q    <= 8'h00;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
      end else begin
         mode      <= next_mode;
         do_sel    <= next_do_sel;
         pos_win   <= next_pos_win;
         pos_lim   <= next_pos_lim;
         spd_arr   <= next_spd_arr;
         trq_spd   <= next_trq_spd;
         zero_spd  <= next_zero_spd;
         hb_thr    <= next_hb_thr;
         hb_hold   <= next_hb_hold;
         hb_dly    <= next_hb_dly;
         hb_spd    <= next_hb_spd;
         int_en    <= next_int_en;
         int_stat  <= next_int_stat;
         wr_pend   <= next_wr_pend;
         rd_pend   <= next_rd_pend;
         addr_q    <= next_addr_q;
         hrdata    <= next_hrdata;
         hreadyout <= next_hreadyout;
      end
   end

   assign hresp = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Millisecond enable, ready timer and alarm latch
   always_comb begin
      next_ms_tick = (ms_cnt == 16'(MS_DIV - 1));
      next_ms_cnt  = next_ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
      next_rdy_cnt = rdy_cnt;
      if (!main_power_in) begin
         next_rdy_cnt = 11'h000;
      end else if (ms_tick && rdy_cnt != 11'(READY_TICKS)) begin
         next_rdy_cnt = rdy_cnt + 11'h001;
      end
      next_excdev = excdev;
      if (alarm_clear_in) begin
         next_excdev = 1'b0;
      end
      if (dev_abs > pos_lim) begin
         next_excdev = 1'b1;
      end
      // A fault code is kept until reset; only excess deviation can be cleared, or replaced by a later fault
      next_err_code = err_code;
      if (err_code == ERR_EXCDEV && !next_excdev) begin
         next_err_code = ERR_NONE;
      end
      if (next_err_code == ERR_NONE || next_err_code == ERR_EXCDEV) begin
         if (fault_in.power_module) begin
            next_err_code = ERR_POWER;
         end else if (fault_in.over_current) begin
            next_err_code = ERR_OVERCUR;
         end else if (fault_in.under_voltage) begin
            next_err_code = ERR_UNDERV;
         end else if (next_excdev) begin
            next_err_code = ERR_EXCDEV;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ms_cnt   <= 16'h0000;
         ms_tick  <= 1'b0;
         rdy_cnt  <= 11'h000;
         excdev   <= 1'b0;
         err_code <= ERR_NONE;
      end else begin
         ms_cnt   <= next_ms_cnt;
         ms_tick  <= next_ms_tick;
         rdy_cnt  <= next_rdy_cnt;
         excdev   <= next_excdev;
         err_code <= next_err_code;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Brake sequencer; an active alarm also drops the enable
   ssos_brake_seq u_brake (
      .hclk          (hclk),
      .hresetn       (hresetn),
      .ms_tick       (ms_tick),
      .run_req       (servo_enable_in && err_code == ERR_NONE),
      .speed_abs     (spd_abs),
      .thr_speed     (hb_thr),
      .hold_ms       (hb_hold),
      .delay_ms      (hb_dly),
      .hb_speed      (hb_spd),
      .brake_release (hb_rel),
      .motor_power   (mtr_pwr),
      .state_code    (hb_state)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Function flags, indexed by output code minus one
   always_comb begin
      next_flags[0] = main_power_in && rdy_cnt == 11'(READY_TICKS)
                      && err_code == ERR_NONE;
      next_flags[1] = err_code != ERR_NONE;
      next_flags[2] = mode == MODE_POS && dev_abs <= pos_win;
      next_flags[3] = hb_rel;
      next_flags[4] = mode == MODE_SPEED && spd_abs > spd_arr;
      next_flags[5] = mode == MODE_TORQUE && spd_abs > trq_spd;
      next_flags[6] = motion_in.homing_done;
      next_flags[7] = spd_abs < zero_spd;
      for (int i = 0; i < 4; i++) begin
         // Code 0 or above 8 leaves the output off
         case (do_sel[i*4 +: 4])
            4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8:
               next_do_out[i] = next_flags[3'(do_sel[i*4 +: 4] - 4'h1)];
            default: next_do_out[i] = 1'b0;
         endcase
      end
      events[EV_ALARM]   = next_flags[1] && !flags[1];
      events[EV_READY]   = next_flags[0] && !flags[0];
      events[EV_POSDONE] = next_flags[2] && !flags[2];
      events[EV_BRAKE]   = !hb_rel && hb_rel_q;
      next_irq = |(next_int_stat & next_int_en);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags     <= 8'h00;
         do_out    <= 4'h0;
         hb_rel_q  <= 1'b0;
         irq       <= 1'b0;
      end else begin
         flags     <= next_flags;
         do_out    <= next_do_out;
         hb_rel_q  <= hb_rel;
         irq       <= next_irq;
      end
   end

   assign drive_ready_out    = flags[0];
   assign alarm_out          = flags[1];
   assign position_done_out  = flags[2];
   assign brake_release_out  = hb_rel;
   assign speed_arrival_out  = flags[4];
   assign torque_arrival_out = flags[5];
   assign homing_done_out    = flags[6];
   assign zero_speed_out     = flags[7];
   assign motor_power_out    = mtr_pwr;
endmodule // ssos_top

// ===== core/ssos_pkg.sv
// Shared constants and types for the servo status output select block.
// Assumes a 40 MHz hclk and an AHB-Lite master with 32-bit data.
package ssos_pkg;
   localparam int          CLK_HZ      = 40_000_000;
   localparam int          READY_MS    = 1500;
   localparam int          MS_CYCLES   = CLK_HZ / 1000;
   localparam int          READY_TICKS = READY_MS;
   localparam logic [7:0] A_MODE      = 8'h00;
   localparam logic [7:0] A_DO_SEL    = 8'h04;
   localparam logic [7:0] A_POS_WIN   = 8'h08;
   localparam logic [7:0] A_POS_LIM   = 8'h0C;
   localparam logic [7:0] A_SPD_ARR   = 8'h10;
   localparam logic [7:0] A_TRQ_SPD   = 8'h14;
   localparam logic [7:0] A_ZERO_SPD  = 8'h18;
   localparam logic [7:0] A_HB_THR    = 8'h1C;
   localparam logic [7:0] A_HB_HOLD   = 8'h20;
   localparam logic [7:0] A_HB_DLY    = 8'h24;
   localparam logic [7:0] A_HB_SPD    = 8'h28;
   localparam logic [7:0] A_STATUS    = 8'h2C;
   localparam logic [7:0] A_INT_STAT  = 8'h30;
   localparam logic [7:0] A_INT_EN    = 8'h34;
   localparam logic [7:0] A_INT_CLR   = 8'h38;
   localparam logic [3:0] ERR_NONE    = 4'h0;
   localparam logic [3:0] ERR_POWER   = 4'h1;
   localparam logic [3:0] ERR_OVERCUR = 4'h2;
   localparam logic [3:0] ERR_UNDERV  = 4'h3;
   localparam logic [3:0] ERR_EXCDEV  = 4'h8;
   localparam int          EV_ALARM    = 0;
   localparam int          EV_READY    = 1;
   localparam int          EV_POSDONE  = 2;
   localparam int          EV_BRAKE    = 3;
   localparam logic [1:0] MODE_POS    = 2'h0;
   localparam logic [1:0] MODE_SPEED  = 2'h1;
   localparam logic [1:0] MODE_TORQUE = 2'h2;
   typedef enum logic [1:0] {
      HB_IDLE  = 2'b00,
      HB_RUN   = 2'b01,
      HB_HOLD  = 2'b11,
      HB_COAST = 2'b10
   } ssos_hb_state_t;
   typedef struct packed {
      logic signed [15:0] speed;
      logic signed [15:0] deviation;
      logic               homing_done;
   } ssos_motion_t;
   typedef struct packed {
      logic power_module;
      logic over_current;
      logic under_voltage;
   } ssos_fault_t;
   function automatic logic [15:0] ssos_abs(input logic signed [15:0] v);
      ssos_abs = v[15] ? 16'(-v) : 16'(v);
   endfunction
endpackage

// ===== core/ssos_brake_seq.sv
// Holding brake and motor power sequencer.
// Assumes a one-cycle millisecond enable from the parent.
`timescale 1ns/100ps
module ssos_brake_seq (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ms_tick,
   input  wire logic        run_req,
   input  wire logic [15:0] speed_abs,
   input  wire logic [15:0] thr_speed,
   input  wire logic [15:0] hold_ms,
   input  wire logic [15:0] delay_ms,
   input  wire logic [15:0] hb_speed,
   output logic             brake_release,
   output logic             motor_power,
   output logic [1:0]       state_code
);
   import ssos_pkg::*;
   ssos_hb_state_t  state, next_state;
   logic [15:0]     ms_cnt, next_ms_cnt;
   logic            next_brake_release, next_motor_power;

   always_comb begin
      next_state = state;
      next_ms_cnt = (ms_tick && ms_cnt != 16'hFFFF) ? ms_cnt + 16'h0001 : ms_cnt;
      case (state)
         HB_IDLE: begin
            if (run_req) begin
               next_state = HB_RUN;
            end
         end
         HB_RUN: begin
            next_ms_cnt = 16'h0000;
            if (!run_req) begin
               if (speed_abs < thr_speed) begin
                  next_state = HB_HOLD;
               end else begin
                  next_state = HB_COAST;
               end
            end
         end
         HB_HOLD: begin
            if (ms_cnt >= hold_ms) begin
               next_state = HB_IDLE;
            end
         end
         HB_COAST: begin
            if (ms_cnt >= delay_ms || speed_abs <= hb_speed) begin
               next_state = HB_IDLE;
            end
         end
         default: next_state = HB_IDLE;
      endcase
      // Brake stays released only while running or coasting down
      next_brake_release = (next_state == HB_RUN) || (next_state == HB_COAST);
      next_motor_power   = (next_state == HB_RUN) || (next_state == HB_HOLD);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state         <= HB_IDLE;
         ms_cnt        <= 16'h0000;
         brake_release <= 1'b0;
         motor_power   <= 1'b0;
      end else begin
         state         <= next_state;
         ms_cnt        <= next_ms_cnt;
         brake_release <= next_brake_release;
         motor_power   <= next_motor_power;
      end
   end

   assign state_code = state;
endmodule // ssos_brake_seq

// ===== tb/ssos_motor_model.sv
// Motor and holding brake seen from the drive's power and brake outputs.
// Assumes speed steps once a cycle when powered with the brake released, so ramps are slow and readable.
`timescale 1ns/100ps
module ssos_motor_model (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               motor_power,
   input  wire logic               brake_release,
   input  wire logic signed [15:0] target,
   output logic signed [15:0]      speed
);
   logic [2:0] div;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         speed <= 16'sh0000;
         div   <= 3'h0;
      end else if (!brake_release && !motor_power) begin
         // Engaged brake on an unpowered shaft clamps it at once
         speed <= 16'sh0000;
      end else if (motor_power && brake_release) begin
         if (speed < target)
            speed <= speed + 16'sh0001;
         else if (speed > target)
            speed <= speed - 16'sh0001;
      end else if (!motor_power) begin
         // Free coast: one step every eight cycles, slower than any powered ramp
         div <= div + 3'h1;
         if (div == 3'h7 && speed > 16'sh0000)
            speed <= speed - 16'sh0001;
      end
   end
endmodule // ssos_motor_model

// ===== tb/ssos_top_sva.sv
// Checker for ssos_top: output timing tied to its inputs, bound to the design.
// Assumes the zero-speed and brake speed registers keep their reset values.
`timescale 1ns/100ps
module ssos_top_sva (
   input wire logic                   hclk,
   input wire logic                   hresetn,
   input wire logic                   hsel,
   input wire logic [1:0]             htrans,
   input wire logic                   hwrite,
   input wire logic                   hready,
   input wire logic                   hreadyout,
   input wire ssos_pkg::ssos_motion_t motion_in,
   input wire ssos_pkg::ssos_fault_t  fault_in,
   input wire logic                   main_power_in,
   input wire logic                   servo_enable_in,
   input wire logic                   alarm_clear_in,
   input wire logic                   drive_ready_out,
   input wire logic                   alarm_out,
   input wire logic                   brake_release_out,
   input wire logic                   homing_done_out,
   input wire logic                   zero_speed_out,
   input wire logic                   motor_power_out
);
   import ssos_pkg::*;
   localparam logic [15:0] ZS   = 16'h000A;
   localparam logic [15:0] THR  = 16'h001E;
   localparam logic [15:0] BSPD = 16'h001E;
   logic [15:0] spd_abs;
   assign spd_abs = motion_in.speed[15] ? 16'(-motion_in.speed) : 16'(motion_in.speed);
   default clocking dc @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read data phase is not one wait state");
   a_ready_power: assert property (!main_power_in |=> !drive_ready_out)
      else $error("ready without main power");
   a_ready_alarm: assert property ($rose(alarm_out) && !alarm_clear_in |=> !drive_ready_out)
      else $error("ready stays during alarm");
   a_alarm_fault: assert property ($rose(|fault_in) && !alarm_out |-> ##2 alarm_out)
      else $error("fault not reported on alarm output");
   a_zero_speed: assert property ($past(hresetn) |-> zero_speed_out == ($past(spd_abs) < ZS))
      else $error("zero speed flag wrong");
   a_homing_flag: assert property ($rose(motion_in.homing_done) |=> homing_done_out)
      else $error("homing done not shown");
   a_enable_run: assert property ($rose(servo_enable_in) && !alarm_out && !brake_release_out
      && !motor_power_out |-> ##2 (brake_release_out && motor_power_out))
      else $error("enable did not release brake and power motor");
   a_stop_hold: assert property ($fell(servo_enable_in) && motor_power_out && brake_release_out
      && spd_abs < THR |-> ##[1:2] (!brake_release_out && motor_power_out))
      else $error("stopped sequence not taken");
   a_run_coast: assert property ($fell(servo_enable_in) && motor_power_out && brake_release_out
      && spd_abs >= THR |-> ##[1:2] (brake_release_out && !motor_power_out))
      else $error("running sequence not taken");
   a_coast_end: assert property (!motor_power_out && brake_release_out && spd_abs <= BSPD
      |-> ##[1:2] !brake_release_out)
      else $error("brake not engaged at brake speed");
   cover property ($rose(drive_ready_out));
   cover property ($fell(servo_enable_in) && motor_power_out && spd_abs >= THR);
   cover property ($rose(alarm_out));
endmodule // ssos_top_sva
bind ssos_top ssos_top_sva i_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .motion_in(motion_in),
   .fault_in(fault_in), .main_power_in(main_power_in), .servo_enable_in(servo_enable_in),
   .alarm_clear_in(alarm_clear_in), .drive_ready_out(drive_ready_out), .alarm_out(alarm_out),
   .brake_release_out(brake_release_out), .homing_done_out(homing_done_out),
   .zero_speed_out(zero_speed_out), .motor_power_out(motor_power_out));

// ===== tb/test_servo_status_output_select.sv
// Self-checking bench for ssos_top with a motor model on the power and brake outputs.
// Assumes one millisecond is shortened to MSD clock cycles.
`timescale 1ns/100ps
module test_servo_status_output_select;
   import ssos_pkg::*;
   localparam int MSD = 10;
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
   $display("FAIL t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
   logic               hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, hom;
   logic               main_power_in, servo_enable_in, alarm_clear_in;
   logic [31:0]        haddr, hwdata, hrdata, rd;
   logic [1:0]         htrans;
   logic [2:0]         hsize;
   logic [3:0]         do_out;
   logic signed [15:0] target, speed, dev;
   ssos_fault_t        fault_in;
   ssos_motion_t       motion_in;
   logic drive_ready_out, alarm_out, position_done_out, brake_release_out, speed_arrival_out;
   logic torque_arrival_out, homing_done_out, zero_speed_out, motor_power_out;
   int                 num_errors = 0;
   int                 n_compared = 0;
   int                 cyc = 0;
   assign motion_in = '{speed: speed, deviation: dev, homing_done: hom};
   assign hready = hreadyout;
   ssos_top #(.MS_DIV(MSD)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .motion_in(motion_in),
      .fault_in(fault_in), .main_power_in(main_power_in), .servo_enable_in(servo_enable_in),
      .alarm_clear_in(alarm_clear_in), .drive_ready_out(drive_ready_out), .alarm_out(alarm_out),
      .position_done_out(position_done_out), .brake_release_out(brake_release_out),
      .speed_arrival_out(speed_arrival_out), .torque_arrival_out(torque_arrival_out),
      .homing_done_out(homing_done_out), .zero_speed_out(zero_speed_out),
      .motor_power_out(motor_power_out), .do_out(do_out), .irq(irq));
   ssos_motor_model i_motor (.hclk(hclk), .hresetn(hresetn), .motor_power(motor_power_out),
      .brake_release(brake_release_out), .target(target), .speed(speed));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      forever begin
         @(posedge hclk);
         cyc++;
         if (cyc == 60000) begin
            num_errors++;
            stop_test();
         end
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic do_reset;
      hresetn <= 1'b0;
      tick(4);
      hresetn <= 1'b1;
   endtask
   // Holds the address phase until hready, then the data phase until hready again
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h00000000);
      `CHK(rd, exp)
      `CHK(hresp, 1'b0)
   endtask
   task automatic clr;
      alarm_clear_in <= 1'b1;
      tick(2);
      alarm_clear_in <= 1'b0;
      tick(4);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_ready;
      tick(READY_TICKS * MSD + 8);
      `CHK(drive_ready_out, 1'b1)
      `CHK(do_out[0], 1'b1)
      bus(A_INT_STAT, 1'b0, 32'h00000000);
      `CHK(rd[1], 1'b1)
      bus(A_INT_EN, 1'b1, 32'h00000002);
      tick(2);
      `CHK(irq, 1'b1)
      bus(A_INT_CLR, 1'b1, 32'h00000002);
      tick(2);
      `CHK(irq, 1'b0)
      rdchk(A_INT_CLR, 32'h00000000);
      rdchk(A_DO_SEL, 32'h00004321);
      rdchk(A_POS_LIM, 32'h00007530);
      bus(8'h3C, 1'b1, 32'hFFFFFFFF);
      rdchk(8'h3C, 32'h00000000);
   endtask
   task automatic t_pos;
      dev <= 16'sh000A;
      tick(4);
      `CHK(position_done_out, 1'b1)
      dev <= 16'sh000B;
      tick(4);
      `CHK(position_done_out, 1'b0)
      dev <= 16'sh7530;
      tick(4);
      `CHK(alarm_out, 1'b0)
      dev <= 16'sh7531;
      tick(4);
      `CHK(do_out[1], 1'b1)
      `CHK(drive_ready_out, 1'b0)
      rdchk(A_STATUS, 32'h00008282);
      clr();
      `CHK(alarm_out, 1'b1)
      dev <= 16'sh0000;
      clr();
      `CHK(alarm_out, 1'b0)
   endtask
   task automatic t_modes;
      bus(A_DO_SEL, 1'b1, 32'h00008765);
      bus(A_MODE, 1'b1, 32'h00000001);
      servo_enable_in <= 1'b1;
      target <= 16'sh01F5;
      tick(600);
      `CHK(do_out, 4'h1)
      target <= 16'sh01F4;
      tick(8);
      `CHK(speed_arrival_out, 1'b0)
      bus(A_MODE, 1'b1, 32'h00000002);
      target <= 16'sh01F5;
      tick(8);
      `CHK({torque_arrival_out, do_out}, 5'h12)
      hom <= 1'b1;
      tick(4);
      `CHK({homing_done_out, do_out}, 5'h16)
      target <= 16'sh000A;
      tick(600);
      `CHK(zero_speed_out, 1'b0)
      target <= 16'sh0009;
      tick(4);
      `CHK(do_out, 4'hC)
   endtask
   task automatic t_brake;
      `CHK(brake_release_out, 1'b1)
      servo_enable_in <= 1'b0;
      tick(3);
      `CHK({brake_release_out, motor_power_out}, 2'b01)
      tick(977);
      `CHK(motor_power_out, 1'b1)
      tick(40);
      `CHK(motor_power_out, 1'b0)
      for (int k = 0; k < 2; k++) begin
         servo_enable_in <= 1'b1;
         target <= 16'sh0064;
         tick(200);
         servo_enable_in <= 1'b0;
         tick(3);
         `CHK({brake_release_out, motor_power_out}, 2'b10)
         tick(k == 0 ? 494 : 177);
         `CHK(brake_release_out, 1'b1)
         tick(k == 0 ? 100 : 40);
         `CHK(brake_release_out, 1'b0)
         bus(A_HB_DLY, 1'b1, 32'h00000014);
      end
   endtask
   task automatic t_faults;
      main_power_in <= 1'b0;
      tick(2);
      `CHK(drive_ready_out, 1'b0)
      for (int i = 0; i < 3; i++) begin
         do_reset();
         fault_in <= 3'b100 >> i;
         tick(4);
         fault_in <= 3'b000;
         `CHK(alarm_out, 1'b1)
         bus(A_STATUS, 1'b0, 32'h00000000);
         `CHK(rd[15:12], 4'(i + 1))
         clr();
         `CHK(alarm_out, 1'b1)
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, hom, main_power_in, servo_enable_in, alarm_clear_in} = 6'h00;
      {haddr, hwdata} = 64'h0000000000000000;
      htrans = 2'h0;
      hsize = 3'h2;
      fault_in = 3'h0;
      {target, dev} = 32'h00000000;
      do_reset();
      main_power_in <= 1'b1;
      t_ready();
      t_pos();
      t_modes();
      t_brake();
      t_faults();
      stop_test();
   end
endmodule // test_servo_status_output_select
